//--- bench/acc_checker.sv
// Port assertions for the converter controller
`timescale 1ns/10ps
module acc_checker
  import acc_pkg::*;
#(
  parameter int unsigned NCH = NUM_CH
) (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_clk_en,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic o_pready,
  input wire logic o_pslverr,
  input wire logic [2:0] o_mux_sel,
  input wire logic o_sample,
  input wire logic o_convert,
  input wire logic o_analog_on,
  input wire logic [NCH-1:0] o_analog_input_lines_sel,
  input wire logic [NCH-1:0] o_ground_input,
  input wire logic o_dma_req,
  input wire logic i_dma_ack
);
  default clocking dc @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  logic wr_en;
  assign wr_en = i_psel && i_penable && i_pwrite;
  chk_ground_inverse: assert property (
    o_ground_input == ~o_analog_input_lines_sel)
    else $error("ground select differs from channel enables");
  chk_pin_handover: assert property (
    wr_en && i_paddr == OFS_CHEN |=> (o_analog_input_lines_sel
    & $past(i_pwdata[NCH-1:0])) == $past(i_pwdata[NCH-1:0]))
    else $error("enabled channel pin not handed over");
  chk_chan_disable: assert property (
    wr_en && i_paddr == OFS_CHDIS |=> (o_analog_input_lines_sel
    & $past(i_pwdata[NCH-1:0])) == '0)
    else $error("disabled channel still selected");
  chk_apb_answer: assert property (
    i_psel |-> o_pready && !o_pslverr)
    else $error("register access not answered");
  chk_stopped_hold: assert property (
    !i_clk_en |=> $stable(o_convert) && $stable(o_sample)
    && $stable(o_mux_sel))
    else $error("conversion moved with clock stopped");
  chk_conv_min: assert property (
    $rose(o_convert) |-> o_convert [*8])
    else $error("conversion phase too short");
  chk_track_first: assert property (
    $rose(o_convert) |-> $past(o_sample))
    else $error("conversion without tracking phase");
  chk_conv_enabled: assert property (
    o_convert |-> o_analog_input_lines_sel[o_mux_sel])
    else $error("conversion on disabled channel");
  chk_core_powered: assert property (
    o_sample || o_convert |-> o_analog_on)
    else $error("core off during conversion");
  chk_dma_ack: assert property (
    i_dma_ack && !o_convert && !$past(o_convert) |=> !o_dma_req)
    else $error("dma request not cleared by acknowledge");
  cover property ($rose(o_convert));
  cover property ($rose(o_dma_req));
  cover property (!i_clk_en && wr_en);
endmodule : acc_checker

bind acc_ctrl acc_checker #(.NCH(NCH)) u_acc_checker (.*);

//--- bench/acc_core_model.sv
// Behavioural converter core answering the controller
`timescale 1ns/10ps
module acc_core_model (
  input wire logic i_clk,
  input wire logic [2:0] i_mux_sel,
  input wire logic i_convert,
  output logic [9:0] o_raw_data,
  output int o_conv_cnt
);
  logic conv_d = 1'b0;
  logic [9:0] junk = 10'h155;
  initial o_conv_cnt = 0;
  always @(posedge i_clk) begin
    conv_d <= i_convert;
    junk <= ~junk;
    if (i_convert && !conv_d) begin
      o_conv_cnt <= o_conv_cnt + 1;
    end
  end
  // Result valid through conversion and store cycle, garbage otherwise
  assign o_raw_data = (i_convert || conv_d) ?
    10'h0a5 + 10'h050 * i_mux_sel : junk;
endmodule : acc_core_model

//--- bench/acc_ctrl_bench.sv
// Self-checking bench of the converter controller
`timescale 1ns/10ps
module acc_ctrl_bench;
  import acc_pkg::*;
  logic i_clk = 1'b0;
  logic i_arst_n = 1'b0;
  logic i_clk_en = 1'b1;
  logic i_psel = 1'b0;
  logic i_penable = 1'b0;
  logic i_pwrite = 1'b0;
  logic [7:0] i_paddr = 8'h00;
  logic [31:0] i_pwdata = 32'h0;
  logic i_external_trigger_pin = 1'b0;
  logic [2:0] i_timer_channel_output = 3'h0;
  logic i_dma_ack = 1'b0;
  logic [RAW_W-1:0] i_raw_data;
  logic [31:0] o_prdata, q, seen;
  logic o_pready, o_pslverr, o_sample, o_convert, o_analog_on;
  logic o_irq, o_dma_req, cv_d, sp_d, irq_seen;
  logic [2:0] o_mux_sel;
  logic [NUM_CH-1:0] o_analog_input_lines_sel, o_ground_input;
  int clen, slen, cnt, base;
  int error_cnt = 0;
  int checks_done = 0;
  always #10 i_clk = ~i_clk;
  acc_ctrl u_acc_ctrl (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .i_clk_en(i_clk_en),
    .i_psel(i_psel),
    .i_penable(i_penable),
    .i_pwrite(i_pwrite),
    .i_paddr(i_paddr),
    .i_pwdata(i_pwdata),
    .o_prdata(o_prdata),
    .o_pready(o_pready),
    .o_pslverr(o_pslverr),
    .i_external_trigger_pin(i_external_trigger_pin),
    .i_timer_channel_output(i_timer_channel_output),
    .i_raw_data(i_raw_data),
    .o_mux_sel(o_mux_sel),
    .o_sample(o_sample),
    .o_convert(o_convert),
    .o_analog_on(o_analog_on),
    .o_analog_input_lines_sel(o_analog_input_lines_sel),
    .o_ground_input(o_ground_input),
    .o_irq(o_irq),
    .o_dma_req(o_dma_req),
    .i_dma_ack(i_dma_ack)
  );
  acc_core_model u_acc_core_model (.i_clk(i_clk), .i_mux_sel(o_mux_sel),
    .i_convert(o_convert), .o_raw_data(i_raw_data), .o_conv_cnt(cnt));
  // Length of the latest tracking and conversion phases
  always @(posedge i_clk) begin
    cv_d <= o_convert;
    sp_d <= o_sample;
    if (o_convert) clen <= cv_d ? clen + 1 : 1;
    if (o_sample) slen <= sp_d ? slen + 1 : 1;
    if (o_irq === 1'b1) irq_seen = 1'b1;
  end
  task automatic conclude();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : conclude
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    logic rdy;
    int n;
    n = 0;
    @(posedge i_clk);
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_clk);
    i_penable <= 1'b1;
    // Answer taken at the edge that samples pready, before it updates
    do begin
      @(posedge i_clk);
      r = o_prdata;
      rdy = o_pready;
      n++;
      if (n > 20) begin
        chk({31'h0, rdy}, 32'h1);
        conclude();
      end
    end while (rdy !== 1'b1);
    i_psel <= 1'b0;
    i_penable <= 1'b0;
    @(negedge i_clk);
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0, q);
  endtask : rd
  task automatic rst();
    @(posedge i_clk);
    i_arst_n <= 1'b0;
    repeat (3) @(posedge i_clk);
    i_arst_n <= 1'b1;
    @(negedge i_clk);
  endtask : rst
  task automatic idle();
    int n;
    n = 0;
    do begin
      rd(OFS_STAT);
      seen = seen | q;
      n++;
    end while (q[STAT_BUSY] !== 1'b0 && n < 4000);
    if (n >= 4000) begin
      chk({31'h0, q[STAT_BUSY]}, 32'h0);
      conclude();
    end
  endtask : idle
  // Start written twice: the second lands while busy and is ignored
  task automatic go(input logic [31:0] m, e, input logic [7:0] ch);
    wr(OFS_MODE, m);
    wr(OFS_EXT, e);
    wr(OFS_CHEN, {24'h0, ch});
    base = cnt;
    seen = 32'h0;
    wr(OFS_CTRL, 32'h2);
    wr(OFS_CTRL, 32'h2);
    idle();
  endtask : go
  task automatic t_reset();
    rst();
    chk({24'h0, o_ground_input}, 32'hff);
    chk({31'h0, o_analog_on}, 32'h1);
    rd(OFS_MODE);
    chk(q, RST_MODE);
    rd(8'h3c);
    chk(q, 32'h0);
    @(posedge i_clk);
    i_clk_en <= 1'b0;
    wr(OFS_CHEN, 32'h81);
    chk({24'h0, o_analog_input_lines_sel}, 32'h81);
    chk({24'h0, o_ground_input}, 32'h7e);
    wr(OFS_CHDIS, 32'h01);
    chk({24'h0, o_analog_input_lines_sel}, 32'h80);
    base = cnt;
    wr(OFS_CTRL, 32'h2);
    repeat (40) @(posedge i_clk);
    chk(32'(cnt - base), 32'h0);
    i_clk_en <= 1'b1;
  endtask : t_reset
  task automatic t_seq();
    rst();
    go(32'h0400_0040, 32'h0, 8'h05);
    chk(32'(cnt - base), 32'h2);
    chk(32'(clen), 32'd11);
    chk(32'(slen), 32'd5);
    chk(q & 32'h0100_0005, 32'h0100_0005);
    chk({31'h0, o_dma_req}, 32'h1);
    @(posedge i_clk);
    i_dma_ack <= 1'b1;
    @(posedge i_clk);
    i_dma_ack <= 1'b0;
    @(negedge i_clk);
    chk({31'h0, o_dma_req}, 32'h0);
    rd(OFS_CHRES);
    chk(q, 32'h0a5);
    rd(OFS_STAT);
    chk(q & 32'h5, 32'h4);
    rd(OFS_LAST);
    chk(q, 32'h0000_8145);
  endtask : t_seq
  task automatic t_res();
    logic [31:0] md [3] = '{32'h50, 32'h40, 32'h40};
    logic [31:0] ex [3] = '{32'h00, 32'h10, 32'h20};
    logic [31:0] rs [3] = '{32'h065, 32'h32a, 32'h654};
    int nc [3] = '{1, 4, 16};
    for (int k = 0; k < 3; k++) begin
      rst();
      go(md[k], ex[k], 8'h08);
      chk(32'(cnt - base), 32'(nc[k]));
      chk(32'(clen), 32'd11);
      rd(OFS_CHRES + 8'h0c);
      chk(q, rs[k]);
    end
  endtask : t_res
  task automatic t_clock();
    // Never both divide bits; dividers kept in converter range
    logic [31:0] md [4] = '{32'h80, 32'h0, 32'h200, 32'hff00};
    int ln [4] = '{33, 22, 66, 5632};
    for (int k = 0; k < 4; k++) begin
      rst();
      go(md[k], 32'h0, 8'h01);
      chk(32'(clen), 32'(ln[k]));
    end
  endtask : t_clock
  task automatic t_trig();
    int n;
    for (int k = 0; k < 4; k++) begin
      rst();
      wr(OFS_MODE, 32'h41 | (32'(k) << MODE_TRGSEL));
      wr(OFS_CHEN, 32'h10);
      base = cnt;
      @(posedge i_clk);
      if (k == 0) i_external_trigger_pin <= 1'b1;
      else i_timer_channel_output <= 3'h1 << (k - 1);
      n = 0;
      while (o_sample !== 1'b1 && n < 50) begin
        @(negedge i_clk);
        n++;
      end
      idle();
      i_external_trigger_pin <= 1'b0;
      i_timer_channel_output <= 3'h0;
      chk(32'(cnt - base), 32'h1);
    end
  endtask : t_trig
  task automatic t_cmp();
    logic e;
    for (int k = 0; k < 8; k++) begin
      rst();
      wr(OFS_WIN, k[2] ? 32'h0fff_0100 : 32'h0080_0040);
      wr(OFS_STAT, 32'h0400_0000);
      irq_seen = 1'b0;
      e = k[1] ? k[0] ^ k[2] : k[0] & !k[2];
      go(32'h40, 32'(k[1:0]), 8'h20);
      chk({31'h0, seen[STAT_COMPE]}, {31'h0, e});
      chk({31'h0, irq_seen}, {31'h0, e});
      chk({31'h0, o_irq}, 32'h0);
    end
  endtask : t_cmp
  task automatic t_last();
    rst();
    wr(OFS_LWIN, 32'h0010_0000);
    go(32'h1000_0060, 32'h0, 8'h81);
    chk({31'h0, o_analog_on}, 32'h0);
    wr(OFS_CTRL, 32'h2);
    idle();
    chk(32'(cnt - base), 32'h3);
    chk({31'h0, seen[STAT_LCMP]}, 32'h1);
  endtask : t_last
  initial begin
    t_reset();
    t_seq();
    t_res();
    t_clock();
    t_trig();
    t_cmp();
    t_last();
    conclude();
  end
endmodule : acc_ctrl_bench

//--- rtl/acc_ctrl.sv
// Converter controller: sequencer, clock divider, averaging, compare, APB
// Functional notes
// (RULE1) Reduced 8-bit result mode keeps the same conversion rate.
// (RULE2) Each result goes to shared and per-channel result registers.
// (RULE3) 11-bit mode averages four raw samples per result.
// (RULE4) 12-bit mode averages sixteen raw samples per result.
// (RULE5) Start by software, external pin rising edge or timer output.
// (RULE6) Last channel converts at its own slower rate.
// (RULE7) Last channel has its own comparison and event.
// (RULE8) Main compare: below, above, inside or outside thresholds.
// (RULE9) Eight inputs multiplexed; each channel enabled individually.
// (RULE10) Enabling a channel hands its shared pin to the converter.
// (RULE11) Disabled channel input grounded; pin stays pulled-up input.
// (RULE12) Register writes work with clock stopped; conversion needs clock.
// (RULE13) Tracking phase of programmed conversion-clock cycles precedes each.
// (RULE14) Prescaler sets conversion clock unless divide-by-one/three set.
// (RULE15) Software never sets divide-by-one and divide-by-three together.
// (RULE16) Next tracking overlaps previous conversion, extending if longer; here tracking starts only after the store cycle.
// (RULE17) Divide-by-one gives peripheral clock; prescaler 255 gives /512.
// (RULE18) Software keeps conversion clock within converter limits.
// (RULE19) One interrupt line for conversion and comparison events.
// (RULE20) One DMA request channel moves results to memory.
// (RULE21) Sleep mode wakes on trigger, converts all, returns low power.
// (RULE22) In 8-bit mode top two result bits read zero.
// (RULE23) Reading a channel result register clears its end flag.
// (RULE24) Writing start bit one begins sequence on enabled channels.
// (RULE25) Triggers during a sleep-mode sequence are ignored.
// (RULE26) Conversion clock is peripheral clock over twice prescaler plus one.
//
// Local design decisions: the placing of the registers and the APB slave port.
`timescale 1ns/10ps
module acc_ctrl
  import acc_pkg::*;
#(
  parameter int unsigned NCH = NUM_CH
) (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_clk_en,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_external_trigger_pin,
  input wire logic [2:0] i_timer_channel_output,
  input wire logic [RAW_W-1:0] i_raw_data,
  output logic [2:0] o_mux_sel,
  output logic o_sample,
  output logic o_convert,
  output logic o_analog_on,
  output logic [NCH-1:0] o_analog_input_lines_sel,
  output logic [NCH-1:0] o_ground_input,
  output logic o_irq,
  output logic o_dma_req,
  input wire logic i_dma_ack
);
  // Register state
  logic [31:0] mode, ext, win, lwin, ie;
  logic [NCH-1:0] chen, eoc;
  logic drdy, compe, lcmp, start_req;
  logic [31:0] next_mode, next_ext, next_win, next_lwin, next_ie;
  logic [NCH-1:0] next_chen, next_eoc;
  logic next_drdy, next_compe, next_lcmp, next_start_req;
  logic [RES_W-1:0] last_res, next_last_res;
  logic [2:0] last_ch, next_last_ch;
  // Sequencer state
  acc_state_type state, next_state;
  logic [8:0] div_cnt, next_div_cnt;
  logic [7:0] ph_cnt, next_ph_cnt;
  logic [3:0] samp_cnt, next_samp_cnt;
  logic [RAW_W+3:0] acc, next_acc;
  logic [2:0] ch, next_ch;
  logic [NCH-1:0] pend, next_pend;
  logic [3:0] lrate, next_lrate;
  logic [RES_W-1:0] rvalue;
  // Pin synchroniser
  logic [3:0] sy1, sy2;
  logic trg_q, next_trg_q;
  // Memory
  logic mem_we;
  logic [RES_W-1:0] mem_rdata;
  logic [2:0] mem_raddr;
  logic [7:0] chres_ofs;
  logic wr, rd, conv_tick, trg_lvl, trg_edge, cmp_hit, lcmp_hit;
  logic [3:0] samp_max;
  logic [RAW_W+3:0] avg_full;
  logic [8:0] div_max;
  logic [2:0] first_ch;

  assign wr = i_psel && i_penable && i_pwrite;
  assign rd = i_psel && i_penable && !i_pwrite;
  assign o_pready = 1'b1;
  assign o_pslverr = 1'b0;
  // Channel index counts from the first result word, not from bit 2
  assign chres_ofs = i_paddr - OFS_CHRES;
  assign mem_raddr = chres_ofs[4:2];

  // Two-stage synchroniser for pin and timer triggers
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sy1 <= 4'h0;
      sy2 <= 4'h0;
    end else begin
      sy1 <= {i_timer_channel_output, i_external_trigger_pin};
      sy2 <= sy1;
    end
  end

  always_comb begin
    trg_lvl = (mode[MODE_TRGSEL +: 3] == TRG_EXT) ? sy2[0] :
      sy2[mode[MODE_TRGSEL +: 2]]; // RULE5
    next_trg_q = trg_lvl;
    trg_edge = mode[MODE_TRGEN] && trg_lvl && !trg_q; // RULE5
  end

  // Conversion-clock divider as one-cycle enable pulse
  always_comb begin
    if (mode[MODE_DIVIDE_BY_ONE_BIT]) begin
      div_max = 9'h000; // RULE17
    end else if (mode[MODE_DIVIDE_BY_THREE_BIT]) begin
      div_max = {1'b0, DIVIDE_BY_THREE_BIT_CNT}; // RULE14
    end else begin
      div_max = {mode[MODE_PRESC +: 8], 1'b1}; // RULE26 RULE17
    end
    samp_max = (ext[EXT_AVG +: 2] == AVG_12) ? SAMP_12 :
      (ext[EXT_AVG +: 2] == AVG_11) ? SAMP_11 : 4'h0; // RULE3 RULE4
    avg_full = acc + {4'h0, i_raw_data};
    if (ext[EXT_AVG +: 2] == AVG_12) begin
      rvalue = avg_full[RAW_W+3:2]; // RULE4
    end else if (ext[EXT_AVG +: 2] == AVG_11) begin
      rvalue = {1'b0, avg_full[RAW_W+1:1]}; // RULE3
    end else if (mode[MODE_REDUCED_RESOLUTION_BIT]) begin
      rvalue = {4'h0, i_raw_data[RAW_W-1:2]}; // RULE1 RULE22
    end else begin
      rvalue = {2'h0, i_raw_data};
    end
    first_ch = 3'h0;
    for (int i = NCH - 1; i >= 0; i--) begin
      if (next_pend[i]) begin
        first_ch = 3'(i);
      end
    end
  end
  assign conv_tick = i_clk_en && (div_cnt == div_max); // RULE12

  // Comparisons
  always_comb begin
    case (ext[EXT_CMPMODE +: 2])
      CMP_LOW: cmp_hit = rvalue < win[11:0]; // RULE8
      CMP_HIGH: cmp_hit = rvalue > win[27:16]; // RULE8
      CMP_IN: cmp_hit = rvalue >= win[11:0] && rvalue <= win[27:16];
      default: cmp_hit = rvalue < win[11:0] || rvalue > win[27:16];
    endcase
    lcmp_hit = rvalue < lwin[11:0] || rvalue > lwin[27:16]; // RULE7
  end

  // Sequencer next state
  always_comb begin
    next_state = state;
    next_div_cnt = div_cnt;
    next_ph_cnt = ph_cnt;
    next_samp_cnt = samp_cnt;
    next_acc = acc;
    next_ch = ch;
    next_pend = pend;
    next_lrate = lrate;
    mem_we = 1'b0;
    if (i_clk_en) begin
      next_div_cnt = conv_tick ? 9'h000 : 9'(div_cnt + 9'h001);
    end
    if (state == ACC_IDLE) begin
      next_pend = chen; // RULE24
      if (chen[NCH-1] && lrate != mode[MODE_LASTDIV +: 4]) begin
        next_pend[NCH-1] = 1'b0; // RULE6
      end
    end
    case (state)
      ACC_IDLE: begin
        if ((start_req || trg_edge) && i_clk_en && |next_pend) begin
          next_state = ACC_TRACK; // RULE21 RULE24
          next_ch = first_ch;
          next_ph_cnt = 8'h00;
          next_samp_cnt = 4'h0;
          next_acc = '0;
          next_lrate = (lrate == mode[MODE_LASTDIV +: 4]) ? 4'h0 :
            4'(lrate + 4'h1);
        end
      end
      ACC_TRACK: begin
        if (conv_tick) begin
          next_ph_cnt = 8'(ph_cnt + 8'h01);
          if (ph_cnt >= {4'h0, mode[MODE_TRACK +: 4]}) begin
            next_state = ACC_CONV; // RULE13 RULE16
            next_ph_cnt = 8'h00;
          end
        end
      end
      ACC_CONV: begin
        if (conv_tick) begin
          next_ph_cnt = 8'(ph_cnt + 8'h01);
          if (ph_cnt == CONV_CYC) begin
            next_state = ACC_STORE;
          end
        end
      end
      ACC_STORE: begin
        next_ph_cnt = 8'h00;
        if (samp_cnt != samp_max) begin
          next_acc = avg_full; // RULE3 RULE4
          next_samp_cnt = 4'(samp_cnt + 4'h1);
          next_state = ACC_TRACK;
        end else begin
          mem_we = 1'b1; // RULE2
          next_pend[ch] = 1'b0;
          next_acc = '0;
          next_samp_cnt = 4'h0;
          next_ch = first_ch;
          next_state = (|next_pend) ? ACC_TRACK : ACC_IDLE; // RULE21
        end
      end
      default: next_state = ACC_IDLE;
    endcase
  end

  // Register next values
  always_comb begin
    next_mode = mode;
    next_ext = ext;
    next_win = win;
    next_lwin = lwin;
    next_ie = ie;
    next_chen = chen;
    next_eoc = eoc;
    next_drdy = drdy;
    next_compe = compe;
    next_lcmp = lcmp;
    next_last_res = last_res;
    next_last_ch = last_ch;
    next_start_req = start_req && state == ACC_IDLE && !i_clk_en;
    if (wr) begin
      case (i_paddr)
        OFS_CTRL: begin
          if (i_pwdata[CTRL_START] && state == ACC_IDLE) begin
            next_start_req = 1'b1; // RULE24 RULE25
          end
        end
        OFS_MODE: next_mode = i_pwdata; // RULE12 RULE15
        OFS_CHEN: next_chen = chen | i_pwdata[NCH-1:0]; // RULE9 RULE10
        OFS_CHDIS: next_chen = chen & ~i_pwdata[NCH-1:0]; // RULE9
        OFS_EXT: next_ext = i_pwdata;
        OFS_WIN: next_win = i_pwdata;
        OFS_LWIN: next_lwin = i_pwdata;
        OFS_STAT: next_ie = i_pwdata;
        default: next_ie = ie;
      endcase
    end
    if (rd) begin
      if (i_paddr >= OFS_CHRES && i_paddr <= OFS_CHRES_END) begin
        next_eoc[mem_raddr] = 1'b0; // RULE23
      end
      if (i_paddr == OFS_LAST) begin
        next_drdy = 1'b0;
      end
      if (i_paddr == OFS_STAT) begin
        next_compe = 1'b0;
        next_lcmp = 1'b0;
      end
    end
    if (i_dma_ack) begin
      next_drdy = 1'b0; // RULE20
    end
    if (mem_we) begin
      next_eoc[ch] = 1'b1; // RULE2
      next_drdy = 1'b1;
      next_last_res = rvalue;
      next_last_ch = ch;
      if (cmp_hit) begin
        next_compe = 1'b1; // RULE8
      end
      if (ch == 3'(NCH - 1) && lcmp_hit) begin
        next_lcmp = 1'b1; // RULE7
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      mode <= RST_MODE;
      ext <= '0;
      win <= '0;
      lwin <= '0;
      ie <= '0;
      chen <= '0;
      eoc <= '0;
      drdy <= 1'b0;
      compe <= 1'b0;
      lcmp <= 1'b0;
      start_req <= 1'b0;
      last_res <= '0;
      last_ch <= 3'h0;
      state <= ACC_IDLE;
      div_cnt <= 9'h000;
      ph_cnt <= 8'h00;
      samp_cnt <= 4'h0;
      acc <= '0;
      ch <= 3'h0;
      pend <= '0;
      lrate <= 4'h0;
      trg_q <= 1'b0;
    end else begin
      mode <= next_mode;
      ext <= next_ext;
      win <= next_win;
      lwin <= next_lwin;
      ie <= next_ie;
      chen <= next_chen;
      eoc <= next_eoc;
      drdy <= next_drdy;
      compe <= next_compe;
      lcmp <= next_lcmp;
      start_req <= next_start_req;
      last_res <= next_last_res;
      last_ch <= next_last_ch;
      state <= next_state;
      div_cnt <= next_div_cnt;
      ph_cnt <= next_ph_cnt;
      samp_cnt <= next_samp_cnt;
      acc <= next_acc;
      ch <= next_ch;
      pend <= next_pend;
      lrate <= next_lrate;
      trg_q <= next_trg_q;
    end
  end

  acc_result_mem #(
    .DEPTH(NCH),
    .WIDTH(RES_W),
    .AW(3)
  ) u_mem (
    .i_clk(i_clk),
    .i_we(mem_we),
    .i_waddr(ch),
    .i_wdata(rvalue),
    .i_raddr(mem_raddr),
    .o_rdata(mem_rdata)
  );

  // Read mux: result memory is read combinationally from its register,
  // so per-channel reads answer with one-cycle address setup
  always_comb begin
    case (i_paddr)
      OFS_MODE: o_prdata = mode;
      OFS_CHSTAT: o_prdata = {24'h0, chen};
      OFS_LAST: o_prdata = {15'h0, last_ch, 2'h0, last_res}; // RULE2
      OFS_STAT: o_prdata = {3'h0, state != ACC_IDLE, lcmp, compe, 1'b0,
        drdy, 16'h0, eoc};
      OFS_EXT: o_prdata = ext;
      OFS_WIN: o_prdata = win;
      OFS_LWIN: o_prdata = lwin;
      default: begin
        if (i_paddr >= OFS_CHRES && i_paddr <= OFS_CHRES_END) begin
          o_prdata = {20'h0, mem_rdata}; // RULE2
        end else begin
          o_prdata = 32'h0;
        end
      end
    endcase
  end

  assign o_mux_sel = ch; // RULE9
  assign o_sample = state == ACC_TRACK; // RULE13
  assign o_convert = state == ACC_CONV;
  assign o_analog_on = !mode[MODE_SLEEP] || state != ACC_IDLE; // RULE21
  assign o_analog_input_lines_sel = chen; // RULE10
  assign o_ground_input = ~chen; // RULE11
  assign o_irq = |(ie[NCH-1:0] & eoc) || (ie[STAT_DRDY] && drdy) ||
    (ie[STAT_COMPE] && compe) || (ie[STAT_LCMP] && lcmp); // RULE19 RULE7
  assign o_dma_req = drdy; // RULE20
endmodule : acc_ctrl

//--- rtl/acc_pkg.sv
// Package of constants for the converter controller
package acc_pkg;
  localparam int unsigned NUM_CH = 8;
  localparam int unsigned RAW_W = 10;
  localparam int unsigned RES_W = 12;
  // APB register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_MODE = 8'h04;
  localparam logic [7:0] OFS_CHEN = 8'h10;
  localparam logic [7:0] OFS_CHDIS = 8'h14;
  localparam logic [7:0] OFS_CHSTAT = 8'h18;
  localparam logic [7:0] OFS_LAST = 8'h20;
  localparam logic [7:0] OFS_STAT = 8'h30;
  localparam logic [7:0] OFS_EXT = 8'h40;
  localparam logic [7:0] OFS_WIN = 8'h44;
  localparam logic [7:0] OFS_LWIN = 8'h48;
  localparam logic [7:0] OFS_CHRES = 8'h50;
  localparam logic [7:0] OFS_CHRES_END = 8'h6c;
  // Control register bits
  localparam int unsigned CTRL_START = 1;
  // Mode register fields
  localparam int unsigned MODE_TRGEN = 0;
  localparam int unsigned MODE_TRGSEL = 1;
  localparam int unsigned MODE_REDUCED_RESOLUTION_BIT = 4;
  localparam int unsigned MODE_SLEEP = 5;
  localparam int unsigned MODE_DIVIDE_BY_ONE_BIT = 6;
  localparam int unsigned MODE_DIVIDE_BY_THREE_BIT = 7;
  localparam int unsigned MODE_PRESC = 8;
  localparam int unsigned MODE_TRACK = 24;
  localparam int unsigned MODE_LASTDIV = 28;
  // Extended mode fields
  localparam int unsigned EXT_CMPMODE = 0;
  localparam int unsigned EXT_AVG = 4;
  // Status bits
  localparam int unsigned STAT_DRDY = 24;
  localparam int unsigned STAT_COMPE = 26;
  localparam int unsigned STAT_LCMP = 27;
  localparam int unsigned STAT_BUSY = 28;
  // Trigger select codes
  localparam logic [2:0] TRG_EXT = 3'h0;
  // Comparison modes
  localparam logic [1:0] CMP_LOW = 2'h0;
  localparam logic [1:0] CMP_HIGH = 2'h1;
  localparam logic [1:0] CMP_IN = 2'h2;
  // Averaging selections
  localparam logic [1:0] AVG_11 = 2'h1;
  localparam logic [1:0] AVG_12 = 2'h2;
  localparam logic [3:0] SAMP_11 = 4'h3;
  localparam logic [3:0] SAMP_12 = 4'hf;
  // Last conversion-clock count of a conversion; divide-by-three divider terminal count
  localparam logic [7:0] CONV_CYC = 8'h0a;
  localparam logic [7:0] DIVIDE_BY_THREE_BIT_CNT = 8'h02;
  localparam logic [31:0] RST_MODE = 32'h0000_0000;
  typedef enum logic [2:0] {
    ACC_IDLE, ACC_TRACK, ACC_CONV, ACC_STORE
  } acc_state_type;
endpackage : acc_pkg

//--- rtl/acc_result_mem.sv
// Per-channel result memory with registered read data
`timescale 1ns/10ps
module acc_result_mem #(
  parameter int unsigned DEPTH = 8,
  parameter int unsigned WIDTH = 12,
  parameter int unsigned AW = 3
) (
  input wire logic i_clk,
  input wire logic i_we,
  input wire logic [AW-1:0] i_waddr,
  input wire logic [WIDTH-1:0] i_wdata,
  input wire logic [AW-1:0] i_raddr,
  output logic [WIDTH-1:0] o_rdata
);
  logic [WIDTH-1:0] mem [DEPTH];
  always_ff @(posedge i_clk) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
    o_rdata <= mem[i_raddr];
  end
endmodule : acc_result_mem
